/* File: usrx_map.vh */
// register offsets, field positions and reset values of the serial port character logic
`ifndef USRX_MAP_VH
`define USRX_MAP_VH
`define USRX_CTRL_OFS      4'h0
`define USRX_MODE_OFS      4'h1
`define USRX_STAT_OFS      4'h2
`define USRX_RHR_OFS       4'h3
`define USRX_THR_OFS       4'h4
`define USRX_GUARD_OFS     4'h5
`define USRX_TMO_OFS       4'h6
`define USRX_BAUD_OFS      4'h7
`define USRX_CMD_STAT_CLR  8
`define USRX_CMD_IDLE_WAIT 11
`define USRX_CMD_ADDR_MARK 12
`define USRX_CMD_IDLE_RELOAD 15
`define USRX_PAR_LSB       9
`define USRX_PAR_EVEN      3'h0
`define USRX_PAR_ODD       3'h1
`define USRX_PAR_SPACE     3'h2
`define USRX_PAR_MARK      3'h3
`define USRX_PAR_NONE      3'h4
`define USRX_ST_RX_READY   0
`define USRX_ST_TX_READY   1
`define USRX_ST_OVERRUN    5
`define USRX_ST_PAR_ERR    7
`define USRX_ST_TMO        8
`define USRX_ST_TX_EMPTY   9
`define USRX_MODE_RESET    32'h0000_0800
`define USRX_PAR_RESET     3'h4
`define USRX_BAUD_RESET    16'h0019
`endif

/* File: usrx_top.v */
// serial port receiver, parity, multidrop, timeguard and idle time-out with wishbone slave
// Behaviour
// - in synchronous mode, sample receive line each bit tick; low starts a character.
// - after start, sample data and parity bits, let the stop bit pass, then hunt for next start; the stop bit is not sampled, RX_STOP ignores rxd.
// - completed character goes to holding register and raises receive ready.
// - character completing while ready set sets overrun and overwrites holding register.
// - overrun clears only by control write with status reset bit one.
// - parity type field selects six parity behaviours, one of them multidrop.
// - even parity: bit is xor of data; receiver flags mismatch.
// - odd parity: bit is inverted xor of data; receiver flags mismatch.
// - mark parity sends one; receiver errors on sampled zero.
// - space parity sends zero; receiver errors on sampled one.
// - no parity: no parity bit sent, no parity error reported.
// - parity error sets flag; cleared by control write with status reset one.
// - types six or seven select multidrop; data parity zero, address parity one.
// - in multidrop, receiver sets parity error when received parity is high.
// - after send address command, next written byte goes with parity one.
// - nonzero guard field holds line high that many bit periods after stop.
// - with guard, transmit ready rises only when next start bit is sent.
// - transmitter empty stays low until guard period has elapsed.
// - zero time-out value disables detection; time-out flag stays zero.
// - nonzero value loads 16-bit counter, decrements per bit, reloads per character.
// - start time-out command halts counter until first character arrives.
// - reload command restarts count at once from programmed value.
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "usrx_map.vh"
module usrx_top #(
	parameter DW = 8
) (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [5:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        rxd,
	output reg         txd
);
	localparam RX_IDLE = 2'd0, RX_DATA = 2'd1, RX_PAR = 2'd2, RX_STOP = 2'd3;
	localparam TX_IDLE = 3'd0, TX_START = 3'd1, TX_DATA = 3'd2, TX_PAR = 3'd3, TX_STOP = 3'd4, TX_GUARD = 3'd5;

	reg  [15:0]   baud_div;
	reg  [15:0]   baud_cnt;
	reg  [2:0]    parity_type_field;
	reg  [7:0]    guard_length_field;
	reg  [15:0]   idle_timeout_value;
	reg  [DW-1:0] receive_holding_reg;
	reg           receive_ready_flag;
	reg           overrun_error_flag;
	reg           parity_error_flag;
	reg           timeout_flag;
	reg  [1:0]    rx_state;
	reg  [3:0]    rx_bit;
	reg  [DW-1:0] rx_shift;
	reg  [15:0]   tmo_cnt;
	reg           tmo_run;
	reg  [DW-1:0] transmit_holding_reg;
	reg           thr_full;
	reg           thr_addr;
	reg           addr_pending;
	reg  [2:0]    tx_state;
	reg  [3:0]    tx_bit;
	reg  [DW-1:0] tx_shift;
	reg           tx_par;
	reg  [7:0]    guard_cnt;
	wire          bit_tick;
	wire          acc;
	wire [3:0]    reg_idx;
	wire          wr;
	wire          rd;
	wire          multidrop;
	wire          par_none;
	wire          rx_done;
	wire          rx_perr;
	wire          sta_clr;
	wire          start_idle_wait_cmd;
	wire          reload_idle_count_cmd;
	wire          tx_load;
	wire          transmit_ready_flag;
	wire          transmitter_empty_flag;
	wire [31:0]   channel_status_reg;
	wire          wr_thr;
	reg           rx_par_bit;

	// bus access; every register is one aligned word, answered one cycle after strobe
	assign acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign reg_idx = wb_adr_i[5:2];
	assign wr      = acc & wb_we_i & wb_sel_i[0];
	assign rd      = acc & ~wb_we_i;
	assign sta_clr = wr & (reg_idx == `USRX_CTRL_OFS) & wb_dat_i[`USRX_CMD_STAT_CLR];
	assign start_idle_wait_cmd   = wr & (reg_idx == `USRX_CTRL_OFS) & wb_dat_i[`USRX_CMD_IDLE_WAIT];
	assign reload_idle_count_cmd = wr & (reg_idx == `USRX_CTRL_OFS) & wb_dat_i[`USRX_CMD_IDLE_RELOAD];
	assign wr_thr  = wr & (reg_idx == `USRX_THR_OFS);
	assign multidrop = parity_type_field[2] & parity_type_field[1];
	assign par_none  = (parity_type_field == `USRX_PAR_NONE) | (parity_type_field == 3'h5);

	// bit-rate enable from the system clock; synchronous serial clock is this tick
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			baud_cnt <= 16'h0000;
		end else if (baud_cnt >= baud_div) begin
			baud_cnt <= 16'h0000;
		end else begin
			baud_cnt <= baud_cnt + 16'h0001;
		end
	end
	assign bit_tick = (baud_cnt >= baud_div);

	// configuration registers and ack
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_ack_o           <= 1'b0;
			parity_type_field  <= `USRX_PAR_RESET;
			guard_length_field <= 8'h00;
			idle_timeout_value <= 16'h0000;
			baud_div           <= `USRX_BAUD_RESET;
			addr_pending       <= 1'b0;
		end else begin
			wb_ack_o <= acc;
			if (wr && reg_idx == `USRX_MODE_OFS) begin
				parity_type_field <= wb_dat_i[`USRX_PAR_LSB+2:`USRX_PAR_LSB];
			end else if (wr && reg_idx == `USRX_GUARD_OFS) begin
				guard_length_field <= wb_dat_i[7:0];
			end else if (wr && reg_idx == `USRX_TMO_OFS && wb_sel_i[1]) begin
				idle_timeout_value <= wb_dat_i[15:0];
			end else if (wr && reg_idx == `USRX_BAUD_OFS && wb_sel_i[1]) begin
				baud_div <= wb_dat_i[15:0];
			end
			// address mark is armed by command and consumed by the next accepted byte
			if (wr && reg_idx == `USRX_CTRL_OFS && wb_dat_i[`USRX_CMD_ADDR_MARK]) begin
				addr_pending <= 1'b1;
			end else if (wr_thr && !thr_full) begin
				addr_pending <= 1'b0;
			end
		end
	end

	assign channel_status_reg = {22'h0, transmitter_empty_flag, timeout_flag, parity_error_flag, 1'b0,
		overrun_error_flag, 3'b000, transmit_ready_flag, receive_ready_flag};

	// read mux; unmapped indices read zero; reading the holding register clears ready
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd) begin
			if (reg_idx == `USRX_MODE_OFS) begin
				wb_dat_o <= {20'h0, parity_type_field, 9'h0};
			end else if (reg_idx == `USRX_STAT_OFS) begin
				wb_dat_o <= channel_status_reg;
			end else if (reg_idx == `USRX_RHR_OFS) begin
				wb_dat_o <= {{(32-DW){1'b0}}, receive_holding_reg};
			end else if (reg_idx == `USRX_GUARD_OFS) begin
				wb_dat_o <= {24'h0, guard_length_field};
			end else if (reg_idx == `USRX_TMO_OFS) begin
				wb_dat_o <= {16'h0, idle_timeout_value};
			end else if (reg_idx == `USRX_BAUD_OFS) begin
				wb_dat_o <= {16'h0, baud_div};
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end

	// receiver: synchronous sampling on every bit tick
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_state   <= RX_IDLE;
			rx_bit     <= 4'h0;
			rx_shift   <= {DW{1'b0}};
			rx_par_bit <= 1'b0;
		end else if (bit_tick) begin
			case (rx_state)
			RX_IDLE: begin
				rx_bit <= 4'h0;
				if (!rxd) begin
					rx_state <= RX_DATA;
				end
			end
			RX_DATA: begin
				rx_shift <= {rxd, rx_shift[DW-1:1]}; // lsb first
				rx_bit   <= rx_bit + 4'h1;
				if (rx_bit == DW - 1) begin
					rx_state <= par_none ? RX_STOP : RX_PAR;
				end
			end
			RX_PAR: begin
				rx_par_bit <= rxd;
				rx_state   <= RX_STOP;
			end
			default: begin
				rx_state <= RX_IDLE; // one stop bit considered, then hunt again
			end
			endcase
		end
	end
	assign rx_done = bit_tick & (rx_state == RX_STOP);

	// parity check per mode
	assign rx_perr = multidrop ? rx_par_bit :
		(parity_type_field == `USRX_PAR_EVEN)  ? (rx_par_bit != ^rx_shift) :
		(parity_type_field == `USRX_PAR_ODD)   ? (rx_par_bit == ^rx_shift) :
		(parity_type_field == `USRX_PAR_SPACE) ? rx_par_bit :
		(parity_type_field == `USRX_PAR_MARK)  ? ~rx_par_bit : 1'b0;

	// holding register and status flags; set wins over clear
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			receive_holding_reg <= {DW{1'b0}};
			receive_ready_flag  <= 1'b0;
			overrun_error_flag  <= 1'b0;
			parity_error_flag   <= 1'b0;
		end else begin
			if (rx_done) begin
				receive_holding_reg <= rx_shift;
				receive_ready_flag  <= 1'b1;
			end else if (rd && reg_idx == `USRX_RHR_OFS) begin
				receive_ready_flag <= 1'b0;
			end
			if (rx_done && receive_ready_flag) begin
				overrun_error_flag <= 1'b1;
			end else if (sta_clr) begin
				overrun_error_flag <= 1'b0;
			end
			if (rx_done && rx_perr) begin
				parity_error_flag <= 1'b1;
			end else if (sta_clr) begin
				parity_error_flag <= 1'b0;
			end
		end
	end

	// idle time-out counter; runs only after a character or a reload command
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tmo_cnt      <= 16'h0000;
			tmo_run      <= 1'b0;
			timeout_flag <= 1'b0;
		end else begin
			if (rx_done || reload_idle_count_cmd) begin
				tmo_cnt <= idle_timeout_value;
				tmo_run <= 1'b1;
			end else if (start_idle_wait_cmd) begin
				tmo_run <= 1'b0;
			end else if (tmo_run && bit_tick && tmo_cnt != 16'h0000) begin
				tmo_cnt <= tmo_cnt - 16'h0001;
			end else if (tmo_run && tmo_cnt == 16'h0000) begin
				tmo_run <= 1'b0; // stop so one expiry gives one flag
			end
			if (idle_timeout_value == 16'h0000) begin
				timeout_flag <= 1'b0;
			end else if (tmo_run && tmo_cnt == 16'h0000 && !rx_done && !reload_idle_count_cmd) begin
				timeout_flag <= 1'b1;
			end else if (start_idle_wait_cmd || reload_idle_count_cmd) begin
				timeout_flag <= 1'b0;
			end
		end
	end

	// transmit holding register; a write while not ready is lost
	// load only once the stop bit and every guard bit have had their full period
	assign tx_load = bit_tick & thr_full & ((tx_state == TX_IDLE) |
		((tx_state == TX_GUARD) & (guard_cnt == 8'h00)));
	assign transmit_ready_flag    = ~thr_full;
	assign transmitter_empty_flag = ~thr_full & (tx_state == TX_IDLE);

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			transmit_holding_reg <= {DW{1'b0}};
			thr_full             <= 1'b0;
			thr_addr             <= 1'b0;
		end else if (wr_thr && !thr_full) begin
			transmit_holding_reg <= wb_dat_i[DW-1:0];
			thr_full             <= 1'b1;
			thr_addr             <= addr_pending;
		end else if (tx_load) begin
			thr_full <= 1'b0;
		end
	end

	// transmitter shift sequence including guard bits
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_state  <= TX_IDLE;
			tx_bit    <= 4'h0;
			tx_shift  <= {DW{1'b0}};
			tx_par    <= 1'b0;
			guard_cnt <= 8'h00;
			txd       <= 1'b1;
		end else if (bit_tick) begin
			if (tx_load) begin
				tx_state <= TX_DATA;
				tx_shift <= transmit_holding_reg;
				tx_bit   <= 4'h0;
				txd      <= 1'b0; // start bit
				if (multidrop) begin
					tx_par <= thr_addr;
				end else if (parity_type_field == `USRX_PAR_EVEN) begin
					tx_par <= ^transmit_holding_reg;
				end else if (parity_type_field == `USRX_PAR_ODD) begin
					tx_par <= ~^transmit_holding_reg;
				end else begin
					tx_par <= (parity_type_field == `USRX_PAR_MARK);
				end
			end else begin
				case (tx_state)
				TX_DATA: begin
					txd      <= tx_shift[0];
					tx_shift <= {1'b0, tx_shift[DW-1:1]};
					tx_bit   <= tx_bit + 4'h1;
					if (tx_bit == DW - 1) begin
						tx_state <= par_none ? TX_STOP : TX_PAR;
					end
				end
				TX_PAR: begin
					txd      <= tx_par;
					tx_state <= TX_STOP;
				end
				TX_STOP: begin
					// the stop bit always passes through guard, so empty stays low until it ends
					txd       <= 1'b1;
					tx_state  <= TX_GUARD;
					guard_cnt <= guard_length_field;
				end
				TX_GUARD: begin
					txd <= 1'b1;
					if (guard_cnt == 8'h00) begin
						tx_state <= TX_IDLE;
					end else begin
						guard_cnt <= guard_cnt - 8'h01;
					end
				end
				default: begin
					txd      <= 1'b1;
					tx_state <= TX_IDLE;
				end
				endcase
			end
		end
	end
endmodule // usrx_top

/* File: usrx_top_props.sv */
// port assertions for the serial port character logic
`timescale 1ns/10ps
module usrx_props (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [5:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        rxd,
	input wire logic        txd
);
	logic h_ovr, h_par, h_tmo, tmo_off;
	wire rd_st = wb_ack_o && !wb_we_i && wb_adr_i[5:2] == 4'h2;
	wire wr_cr = wb_ack_o && wb_we_i && wb_adr_i[5:2] == 4'h0;
	wire wr_to = wb_ack_o && wb_we_i && wb_adr_i[5:2] == 4'h6 && wb_sel_i[1:0] == 2'h3;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// flags software last saw; only a command, or for time-out a time-out register write, may drop them, so forget each on what clears it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{h_ovr, h_par, h_tmo} <= 3'h0;
			tmo_off <= 1'b1;
		end else if (rd_st) begin
			{h_ovr, h_par, h_tmo} <= {wb_dat_o[5], wb_dat_o[7], wb_dat_o[8]};
		end else if (wr_cr) begin
			h_ovr <= h_ovr & !wb_dat_i[8];
			h_par <= h_par & !wb_dat_i[8];
			h_tmo <= h_tmo & !(wb_dat_i[11] | wb_dat_i[15]);
		end else if (wr_to) begin
			h_tmo <= 1'b0;
			tmo_off <= wb_dat_i[15:0] == 16'h0;
		end
	end
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("stray ack");
	unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[5] |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	overrun_hold_a: assert property (rd_st && h_ovr |-> wb_dat_o[5]) else $error("overrun dropped");
	parity_hold_a: assert property (rd_st && h_par |-> wb_dat_o[7]) else $error("parity flag dropped");
	timeout_hold_a: assert property (rd_st && h_tmo |-> wb_dat_o[8]) else $error("timeout dropped");
	timeout_off_a: assert property (rd_st && tmo_off |-> !wb_dat_o[8]) else $error("timeout while off");
endmodule // usrx_props
bind usrx_top usrx_props u_props (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rxd(rxd), .txd(txd));

/* File: usrx_remote.sv */
// remote serial device: drives the receive line, captures the transmit line
`timescale 1ns/10ps
module usrx_remote #(
	parameter int BIT_CLKS = 4
) (
	input  wire logic sys_clk,
	input  wire logic txd,
	output logic      rxd
);
	// line rests high between frames
	initial rxd = 1'b1;
	// start, data lsb first, optional parity, one stop; one bit per bit period
	task automatic send(input logic [7:0] d, input logic hp, input logic p);
		logic [10:0] f;
		f = {1'b1, p, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			if (i != 9 || hp) begin
				rxd <= f[i];
				repeat (BIT_CLKS) @(posedge sys_clk);
			end
		end
	endtask
	// sample mid-bit on the falling edge, clear of txd updates; n is the idle wait
	task automatic grab(output logic [7:0] d, output logic p, output int n);
		n = 0;
		while (txd !== 1'b0 && n < 5000) begin
			@(negedge sys_clk);
			n++;
		end
		repeat (BIT_CLKS / 2) @(negedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CLKS) @(negedge sys_clk);
			if (i < 8) d[i] = txd;
			else p = txd;
		end
		// return at the start of the stop bit so the next idle wait counts stop plus guard
		repeat (BIT_CLKS / 2) @(negedge sys_clk);
		@(posedge sys_clk);
	endtask
endmodule // usrx_remote

/* File: usrx_top_tb_top.sv */
// self-checking bench for the serial port character logic
`timescale 1ns/10ps
module usrx_top_tb_top;
	localparam int BC = 4;
	logic        sys_clk, rst, cyc, stb, we, ack, rxd, txd;
	logic [5:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q, lfsr;
	int          bad_count, tests_run;
	usrx_top u_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rxd(rxd), .txd(txd));
	usrx_remote #(.BIT_CLKS(BC)) u_rem (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// parity error expected for a received parity bit p
	function automatic logic exp_pe(input int m, input logic [7:0] d, input logic p);
		case (m)
			0: return p != ^d;
			1: return p == ^d;
			2, 6, 7: return p;
			3: return !p;
			default: return 1'b0;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one classic cycle; hold everything until ack is sampled, then one idle cycle
	task automatic bus(input logic w, input int idx, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= 6'(idx * 4);
		wdat <= d;
		// no latency is assumed; only the watchdog ends a hung wait
		do begin
			@(posedge sys_clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic poll(input int b);
		int k;
		k = 0;
		do begin
			bus(0, 2, 0);
			k++;
		end while (q[b] !== 1'b1 && k < 200);
		chk("poll_flag", 1, 32'(q[b]));
	endtask
	task automatic tx_pair(input int m, input int g, input logic sa);
		logic [7:0] d0, d1;
		logic p0, p1;
		int n0, n1;
		lfsr = nxt(lfsr);
		bus(1, 1, 32'(m) << 9);
		bus(1, 5, 32'(g));
		fork
			begin
				u_rem.grab(d0, p0, n0);
				u_rem.grab(d1, p1, n1);
			end
			begin
				if (sa) bus(1, 0, 32'h1000);
				bus(1, 4, {24'h0, lfsr[7:0]});
				poll(1);
				bus(1, 4, {24'h0, lfsr[15:8]});
				bus(0, 2, 0);
				chk("tx_ready", 0, 32'(q[1]));
			end
		join
		chk("tx_data0", 32'(lfsr[7:0]), 32'(d0));
		chk("tx_data1", 32'(lfsr[15:8]), 32'(d1));
		chk("tx_par0", m == 0 ? 32'(^d0) : 32'(sa), 32'(p0));
		chk("tx_par1", m == 0 ? 32'(^d1) : 0, 32'(p1));
		chk("tx_gap", 32'(1 + g), 32'(n1 / BC));
		bus(0, 2, 0);
		chk("tx_empty", 0, 32'(q[9]));
		poll(9);
		$display("test tx mode %0d guard %0d done", m, g);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		{rst, cyc, stb, we, sel, adr, wdat} = {1'b1, 45'h0};
		lfsr = 32'h295f_b7fa;
		bad_count = 0;
		tests_run = 0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		bus(0, 1, 0);
		chk("mode_reset", 32'h0800, q);
		bus(0, 7, 0);
		chk("baud_reset", 32'h0019, q);
		bus(0, 9, 0);
		chk("unmapped", 0, q);
		bus(1, 7, BC - 1);
		// every parity type on random data, with both parity bit values except in types 4 and 5
		for (int m = 0; m < 8; m++) begin
			bus(1, 1, 32'(m) << 9);
			for (int p = 0; p < 2; p++) begin
				lfsr = nxt(lfsr);
				u_rem.send(lfsr[7:0], m < 4 || m > 5, p[0]);
				bus(0, 2, 0);
				chk("parity_err", 32'(exp_pe(m, lfsr[7:0], p[0])), 32'(q[7]));
				chk("rx_ready", 1, 32'(q[0]));
				bus(0, 3, 0);
				chk("rx_data", 32'(lfsr[7:0]), q);
				bus(0, 2, 0);
				chk("parity_hold", 32'(exp_pe(m, lfsr[7:0], p[0])), 32'(q[7]));
				bus(1, 0, 32'h0100);
			end
		end
		$display("test parity done");
		// mode is multidrop here, so frames carry a parity bit to stay in step
		u_rem.send(8'h5a, 1, 0);
		u_rem.send(8'ha5, 1, 0);
		bus(0, 2, 0);
		chk("overrun", 1, 32'(q[5]));
		bus(0, 3, 0);
		chk("rx_last", 32'h00a5, q);
		bus(0, 2, 0);
		chk("overrun_hold", 1, 32'(q[5]));
		bus(1, 0, 32'h0100);
		bus(0, 2, 0);
		chk("overrun_clr", 0, 32'(q[5]));
		$display("test overrun done");
		tx_pair(0, 2, 0);
		tx_pair(6, 0, 1);
		bus(1, 6, 5);
		bus(1, 0, 32'h8000);
		bus(0, 2, 0);
		chk("tmo_early", 0, 32'(q[8]));
		repeat (8 * BC) @(posedge sys_clk);
		bus(0, 2, 0);
		chk("tmo_reload", 1, 32'(q[8]));
		bus(0, 2, 0);
		chk("tmo_hold", 1, 32'(q[8]));
		bus(1, 0, 32'h0800);
		repeat (10 * BC) @(posedge sys_clk);
		bus(0, 2, 0);
		chk("tmo_wait", 0, 32'(q[8]));
		lfsr = nxt(lfsr);
		u_rem.send(lfsr[7:0], 1, 0);
		repeat (8 * BC) @(posedge sys_clk);
		bus(0, 2, 0);
		chk("tmo_char", 1, 32'(q[8]));
		bus(1, 6, 0);
		bus(0, 2, 0);
		chk("tmo_off", 0, 32'(q[8]));
		$display("test timeout done");
		report_and_stop();
	end
endmodule // usrx_top_tb_top
